// >>> shared/sps_defines.vh
// constants for the serial master/slave port
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH
`define SPS_MODE_M4 4'h0
`define SPS_MODE_M16 4'h1
`define SPS_MODE_M64 4'h2
`define SPS_MODE_MTMR 4'h3
`define SPS_MODE_SSEL 4'h4
`define SPS_MODE_SNOSEL 4'h5
`define SPS_HALF_M4 6'h02
`define SPS_HALF_M16 6'h08
`define SPS_HALF_M64 6'h20
`define SPS_BITS 4'h8
`define SPS_FIFO_W 8
`define SPS_FIFO_D 16
`define SPS_FIFO_AW 4
`endif

// >>> design/sps_port.v
// serial master/slave port with receive fifo
`timescale 1ns/1ps
`default_nettype none
`include "sps_defines.vh"
// =========================================================
// receive fifo
module sps_fifo #(
    parameter W = 8,
    parameter D = 16,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire srst,
    input wire inValid,
    output wire inReady,
    input wire [W-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [W-1:0] outData
);
    reg [W-1:0] mem [0:D-1];
    reg [AW-1:0] wrPtr_reg;
    reg [AW-1:0] rdPtr_reg;
    reg [AW:0] count_reg;
    wire doWr = inValid && inReady;
    wire doRd = outValid && outReady;
    assign inReady = (count_reg != D);
    assign outValid = (count_reg != 0);
    assign outData = mem[rdPtr_reg];
    always @(posedge clk_sys) begin
        if (doWr) begin
            mem[wrPtr_reg] <= inData;
        end
        if (srst) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (doWr) wrPtr_reg <= wrPtr_reg + 1'b1;
            if (doRd) rdPtr_reg <= rdPtr_reg + 1'b1;
            if (doWr && !doRd) count_reg <= count_reg + 1'b1;
            else if (doRd && !doWr) count_reg <= count_reg - 1'b1;
        end
    end
endmodule // sps_fifo

// =========================================================
// port top
module sps_port (
    input wire clk_sys,
    input wire srst,
    input wire portEnable,
    input wire clockIdleLevel,
    input wire clockEdgeSel,
    input wire samplePhase,
    input wire [3:0] portModeField,
    input wire sleepMode,
    input wire timerTwoTick,
    input wire bufWrite,
    input wire [7:0] bufWrData,
    input wire bufRead,
    output reg [7:0] bufRdData,
    output reg bufferFullFlag,
    input wire clrIrq,
    output reg portIrqFlag,
    input wire clrCollision,
    output reg writeCollisionFlag,
    input wire clrOverflow,
    output reg receiveOverflowFlag,
    output reg pinsOwned,
    input wire sckIn,
    output reg sckOut,
    output reg sckOe,
    input wire serialInPin,
    output reg serialOutPin,
    output reg serialOutOe,
    input wire selectN,
    output reg [7:0] rxStreamData,
    output reg rxStreamValid,
    input wire rxStreamReady
);
    // =====================================================
    // pin synchronisers
    reg [2:0] sckSync_reg;
    reg [2:0] sdiSync_reg;
    reg [2:0] selSync_reg;
    reg [2:0] tmrSync_reg;
    reg sckLvl_reg;
    reg selLvl_reg;
    reg tmrPhase_reg;
    always @(posedge clk_sys) begin
        if (srst) begin
            sckSync_reg <= 3'h0;
            sdiSync_reg <= 3'h0;
            selSync_reg <= 3'h7;
            tmrSync_reg <= 3'h0;
            sckLvl_reg <= 1'b0;
            selLvl_reg <= 1'b1;
        end else begin
            sckSync_reg <= {sckSync_reg[1:0], sckIn};
            sdiSync_reg <= {sdiSync_reg[1:0], serialInPin};
            selSync_reg <= {selSync_reg[1:0], selectN};
            tmrSync_reg <= {tmrSync_reg[1:0], timerTwoTick};
            // change counts once stages two and three agree
            if (sckSync_reg[1] == sckSync_reg[2])
                sckLvl_reg <= sckSync_reg[2];
            if (selSync_reg[1] == selSync_reg[2])
                selLvl_reg <= selSync_reg[2];
        end
    end
    wire sdiLvl = sdiSync_reg[2];
    wire tmrRise = tmrSync_reg[1] && !tmrSync_reg[2];

    // =====================================================
    // mode decode
    wire isMaster = (portModeField[3:2] == 2'b00);
    wire isSelSlave = (portModeField == `SPS_MODE_SSEL);
    wire isSlave = isSelSlave ||
        (portModeField == `SPS_MODE_SNOSEL);
    wire selHigh = isSelSlave && selLvl_reg;
    wire portReset = !portEnable || selHigh;

    // =====================================================
    // receive fifo feeding the stream port
    wire fifoInReady;
    wire fifoOutValid;
    wire [7:0] fifoOutData;
    reg fifoPush;
    reg [7:0] fifoPushData;
    wire streamTake = !rxStreamValid || rxStreamReady;
    sps_fifo #(
        .W(`SPS_FIFO_W),
        .D(`SPS_FIFO_D),
        .AW(`SPS_FIFO_AW)
    ) rxFifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .inValid(fifoPush),
        .inReady(fifoInReady),
        .inData(fifoPushData),
        .outValid(fifoOutValid),
        .outReady(streamTake),
        .outData(fifoOutData)
    );

    // =====================================================
    // shift engine
    localparam ST_IDLE = 2'b01;
    localparam ST_SHIFT = 2'b10;
    reg [1:0] state_reg;
    reg [7:0] shift_reg;
    reg [3:0] bitCnt_reg;
    reg [5:0] div_reg;
    reg phase_reg; // 0: first half of bit, 1: second half
    reg sckPrev_reg;
    reg [2:0] sampDly_reg;
    reg [2:0] lastDly_reg;
    reg [7:0] rxCap_reg;
    wire [5:0] halfCnt = (portModeField == `SPS_MODE_M16) ?
        `SPS_HALF_M16 : (portModeField == `SPS_MODE_M64) ?
        `SPS_HALF_M64 : `SPS_HALF_M4;
    wire busy = (state_reg == ST_SHIFT);
    // master tick: divider or timer edge; sleep stops it
    wire masterTick = !sleepMode && ((portModeField ==
        `SPS_MODE_MTMR) ? tmrRise : (div_reg == 6'h01));
    // slave clock edges: leading leaves idle level
    wire sckEdge = sckLvl_reg != sckPrev_reg;
    wire leadEdge = sckEdge && (sckPrev_reg == clockIdleLevel);
    // edge select set: latch on the leading edge
    wire latchEdge = clockEdgeSel ? leadEdge : (sckEdge && !leadEdge);
    wire byteDone = (bitCnt_reg == `SPS_BITS - 4'h1);
    // input lags three clocks in its synchroniser, so the
    // master takes each bit three clocks after its sck tick
    wire sampTick = isMaster && busy && masterTick &&
        (phase_reg == samplePhase);
    wire lastTick = isMaster && busy && masterTick && phase_reg && byteDone;
    wire [7:0] masterByte = sampDly_reg[2] ? {rxCap_reg[6:0], sdiLvl} :
        rxCap_reg;
    // a write before the last bit is in counts as a collision
    wire mBusy = busy || (lastDly_reg != 3'h0);
    reg [7:0] nextShift;
    reg done;
    always @* begin
        nextShift = {shift_reg[6:0], sdiLvl};
        done = 1'b0;
        if (isMaster && lastDly_reg[2])
            done = 1'b1;
        if (isSlave && latchEdge && byteDone &&
            !(isSelSlave && selLvl_reg))
            done = 1'b1;
    end

    always @(posedge clk_sys) begin
        fifoPush <= 1'b0;
        if (srst || portReset) begin
            state_reg <= ST_IDLE;
            bitCnt_reg <= 4'h0;
            div_reg <= `SPS_HALF_M4;
            phase_reg <= 1'b0;
            sckPrev_reg <= clockIdleLevel;
            sckOut <= clockIdleLevel;
            sampDly_reg <= 3'h0;
            lastDly_reg <= 3'h0;
            if (srst) begin
                shift_reg <= 8'h00;
                bufRdData <= 8'h00;
                bufferFullFlag <= 1'b0;
                portIrqFlag <= 1'b0;
                writeCollisionFlag <= 1'b0;
                receiveOverflowFlag <= 1'b0;
                fifoPushData <= 8'h00;
                rxCap_reg <= 8'h00;
            end
        end else begin
            sckPrev_reg <= sckLvl_reg;
            sampDly_reg <= {sampDly_reg[1:0], sampTick};
            lastDly_reg <= {lastDly_reg[1:0], lastTick};
            if (sampDly_reg[2]) rxCap_reg <= masterByte;
            // clears lose to sets in the same cycle
            if (bufRead) bufferFullFlag <= 1'b0;
            if (clrIrq) portIrqFlag <= 1'b0;
            if (clrCollision) writeCollisionFlag <= 1'b0;
            if (clrOverflow) receiveOverflowFlag <= 1'b0;
            if (bufWrite) begin
                if (mBusy || (isSlave && bitCnt_reg != 4'h0))
                    writeCollisionFlag <= 1'b1;
                else begin
                    shift_reg <= bufWrData;
                    if (isMaster) begin
                        state_reg <= ST_SHIFT;
                        div_reg <= halfCnt;
                        phase_reg <= 1'b0;
                        // clock starts at its idle level; msb is on the pin first
                        sckOut <= clockIdleLevel;
                    end
                end
            end
            if (isMaster && busy && masterTick) begin
                div_reg <= halfCnt;
                sckOut <= ~sckOut;
                if (!phase_reg) begin
                    phase_reg <= 1'b1;
                end else begin
                    phase_reg <= 1'b0;
                    // received bits land in rxCap_reg, later
                    shift_reg <= {shift_reg[6:0], 1'b0};
                    bitCnt_reg <= byteDone ? 4'h0 : bitCnt_reg + 4'h1;
                    if (byteDone) begin
                        state_reg <= ST_IDLE;
                        sckOut <= clockIdleLevel;
                    end
                end
            end else if (isMaster && busy && !sleepMode) begin
                div_reg <= div_reg - 6'h01;
            end else if (!busy) begin
                sckOut <= clockIdleLevel;
            end
            if (isSlave && latchEdge) begin
                shift_reg <= nextShift;
                bitCnt_reg <= byteDone ? 4'h0 : bitCnt_reg + 4'h1;
            end
            if (done) begin
                portIrqFlag <= 1'b1;
                if (isSlave && bufferFullFlag && !bufRead)
                    receiveOverflowFlag <= 1'b1;
                else begin
                    bufRdData <= isMaster ? masterByte :
                        nextShift;
                    bufferFullFlag <= 1'b1;
                    fifoPushData <= isMaster ? masterByte : nextShift;
                    // a full fifo drops the copy, not the buffer
                    fifoPush <= fifoInReady;
                end
            end
        end
    end

    // =====================================================
    // pins and stream outputs
    always @(posedge clk_sys) begin
        if (srst) begin
            pinsOwned <= 1'b0;
            sckOe <= 1'b0;
            serialOutPin <= 1'b0;
            serialOutOe <= 1'b0;
            rxStreamValid <= 1'b0;
            rxStreamData <= 8'h00;
        end else begin
            pinsOwned <= portEnable;
            sckOe <= portEnable && isMaster;
            serialOutPin <= shift_reg[7];
            serialOutOe <= portEnable && (isMaster ||
                (isSlave && !selHigh));
            if (streamTake) begin
                rxStreamValid <= fifoOutValid;
                rxStreamData <= fifoOutData;
            end
        end
    end
endmodule // sps_port
`default_nettype wire

// >>> dv/sps_spi_peer.sv
// spi peer model facing the port in master mode
`timescale 1ns/1ps
`default_nettype none
module sps_spi_peer (
    input wire logic sck,
    input wire logic mosi,
    input wire logic load,
    input wire logic [7:0] txByte,
    output logic miso,
    output logic [7:0] rxByte
);
    // ====
    // idle-low clock; past the byte the line keeps changing
    logic [7:0] shReg = 8'h00;
    initial rxByte = 8'h00;
    always @(posedge load or negedge sck) begin
        if (load) begin
            shReg <= txByte;
        end else begin
            shReg <= {shReg[6:0], ~shReg[7]};
        end
    end
    always @(posedge sck) begin
        rxByte <= {rxByte[6:0], mosi};
    end
    assign miso = shReg[7];
endmodule // sps_spi_peer
`default_nettype wire

// >>> dv/sps_port_chk.sv
// assertions on the serial port pins and flags
`timescale 1ns/1ps
`default_nettype none
module sps_port_chk (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic portEnable,
    input wire logic clockIdleLevel,
    input wire logic [3:0] portModeField,
    input wire logic sleepMode,
    input wire logic bufWrite,
    input wire logic bufRead,
    input wire logic [7:0] bufRdData,
    input wire logic bufferFullFlag,
    input wire logic portIrqFlag,
    input wire logic writeCollisionFlag,
    input wire logic receiveOverflowFlag,
    input wire logic sckOut,
    input wire logic sckOe,
    input wire logic serialOutOe,
    input wire logic selectN
);
    // ====
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_full_irq: assert property ($rose(bufferFullFlag) |-> portIrqFlag)
        else $error("full without irq");
    a_read_clears: assert property ($fell(bufferFullFlag) |->
        $past(bufRead) || $past(srst)) else $error("full fell unread");
    a_coll_cause: assert property ($rose(writeCollisionFlag) |->
        $past(bufWrite)) else $error("collision without write");
    a_idle_level: assert property (!portEnable && !$past(portEnable) &&
        $stable(clockIdleLevel) |-> sckOut == clockIdleLevel)
        else $error("clock idle level wrong");
    a_oe_master: assert property (sckOe |-> portModeField < 4'h4 &&
        ($past(portEnable) || $past(portEnable, 2)))
        else $error("clock driven outside master");
    a_sel_float: assert property ((portModeField == 4'h4 && selectN) [*5]
        |=> !serialOutOe) else $error("output driven deselected");
    a_hold_data: assert property (bufferFullFlag && !bufRead &&
        portModeField >= 4'h4 |=> $stable(bufRdData))
        else $error("full buffer overwritten");
    a_ovf_cause: assert property ($rose(receiveOverflowFlag) |->
        $past(bufferFullFlag)) else $error("overflow while empty");
    a_sleep_freeze: assert property ((sleepMode && portModeField < 4'h4) [*3]
        |-> $stable(sckOut)) else $error("clock ran in sleep");
endmodule // sps_port_chk
`default_nettype wire

// >>> dv/sps_port_tb.sv
// self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module sps_port_tb;
    // ====
    logic clk_sys = 1'h0, srst = 1'h1, portEnable = 1'h0;
    logic clockIdleLevel = 1'h0, clockEdgeSel = 1'h0, samplePhase = 1'h0;
    logic [3:0] portModeField = 4'h0;
    logic sleepMode = 1'h0, bufWrite = 1'h0, bufRead = 1'h0, clrIrq = 1'h0;
    logic clrCollision = 1'h0, clrOverflow = 1'h0, sckIn = 1'h0;
    logic selectN = 1'h1, rxStreamReady = 1'h0, tbSdi = 1'h0, peerLoad = 1'h0;
    logic [7:0] bufWrData = 8'h00, peerTx = 8'h00, bufRdData, rxStreamData;
    logic [7:0] peerRx;
    logic [2:0] tmrCnt = 3'h0;
    logic bufferFullFlag, portIrqFlag, writeCollisionFlag, receiveOverflowFlag;
    logic pinsOwned, sckOut, sckOe, serialOutPin, serialOutOe, rxStreamValid;
    logic peerMiso;
    int failures = 0, totalChecks = 0, cycles = 0;
    // timer tick rises every 8 clocks
    wire timerTwoTick = tmrCnt[2];
    wire serialInPin = portModeField >= 4'h4 ? tbSdi : peerMiso;
    always #2 clk_sys = ~clk_sys;
    sps_port u_sps_port (.clk_sys, .srst, .portEnable, .clockIdleLevel,
        .clockEdgeSel, .samplePhase, .portModeField, .sleepMode, .timerTwoTick,
        .bufWrite, .bufWrData, .bufRead, .bufRdData, .bufferFullFlag, .clrIrq,
        .portIrqFlag, .clrCollision, .writeCollisionFlag, .clrOverflow,
        .receiveOverflowFlag, .pinsOwned, .sckIn, .sckOut, .sckOe, .serialInPin,
        .serialOutPin, .serialOutOe, .selectN, .rxStreamData, .rxStreamValid,
        .rxStreamReady);
    sps_spi_peer u_sps_spi_peer (.sck(sckOut), .mosi(serialOutPin),
        .load(peerLoad), .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        tmrCnt <= tmrCnt + 3'h1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end
    // reconfigure only while disabled
    task automatic cfg(input logic [3:0] m, input logic e);
        @(posedge clk_sys);
        portEnable <= 1'h0;
        repeat (2) @(posedge clk_sys);
        portModeField <= m;
        clockEdgeSel <= e;
        samplePhase <= m == 4'h3;
        repeat (3) @(posedge clk_sys);
        portEnable <= 1'h1;
        repeat (4) @(posedge clk_sys);
        check("pinsOwned", {7'h0, pinsOwned}, 8'h01);
    endtask
    task automatic rd;
        @(posedge clk_sys);
        {bufRead, clrIrq, clrCollision, clrOverflow} <= 4'hf;
        @(posedge clk_sys);
        {bufRead, clrIrq, clrCollision, clrOverflow} <= 4'h0;
        @(negedge clk_sys);
        check("bufferFullFlag", {7'h0, bufferFullFlag}, 8'h00);
    endtask
    task automatic mx(input logic [7:0] d, input logic [7:0] r, input int half,
        input logic coll, input logic slp);
        int n;
        n = 0;
        @(posedge clk_sys);
        peerTx <= r;
        peerLoad <= 1'h1;
        @(posedge clk_sys);
        peerLoad <= 1'h0;
        bufWrite <= 1'h1;
        bufWrData <= d;
        while (bufferFullFlag !== 1'h1 && n < 1000) begin
            @(posedge clk_sys);
            n++;
            bufWrite <= coll && n == 4;
            bufWrData <= 8'hff;
            sleepMode <= slp && n > 8 && n < 28;
            #1;
        end
        @(negedge clk_sys);
        check("bufRdData", bufRdData, r);
        check("peerRx", peerRx, d);
        check("portIrqFlag", {7'h0, portIrqFlag}, 8'h01);
        check("byteTime", {7'h0, n > 15 * half && n < 18 * half + 30}, 8'h01);
        check("writeCollisionFlag", {7'h0, writeCollisionFlag}, {7'h0, coll});
        rd();
    endtask
    // slow external clock: sync delay needs several clocks per phase
    task automatic sb(input logic [7:0] d, input int nb);
        for (int i = 7; i > 7 - nb; i--) begin
            @(posedge clk_sys);
            tbSdi <= d[i];
            repeat (8) @(posedge clk_sys);
            sckIn <= 1'h1;
            repeat (8) @(posedge clk_sys);
            sckIn <= 1'h0;
            repeat (7) @(posedge clk_sys);
        end
        tbSdi <= ~d[8-nb];
        repeat (8) @(posedge clk_sys);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        srst <= 1'h0;
        clockIdleLevel <= 1'h1;
        repeat (3) @(negedge clk_sys);
        check("sckOut", {7'h0, sckOut}, 8'h01);
        @(posedge clk_sys);
        clockIdleLevel <= 1'h0;
        cfg(4'h0, 1'h1);
        check("sckOut", {7'h0, sckOut}, 8'h00);
        mx(8'ha5, 8'h3c, 2, 1'h1, 1'h0);
        mx(8'h81, 8'h7e, 2, 1'h0, 1'h1);
        for (int m = 1; m < 4; m++) begin
            cfg(m[3:0], 1'h1);
            mx(8'h0f, 8'hf0, m == 2 ? 32 : 8, 1'h0, 1'h0);
        end
        cfg(4'h5, 1'h0);
        sleepMode <= 1'h1;
        sb(8'h96, 8);
        check("bufRdData", bufRdData, 8'h96);
        check("portIrqFlag", {7'h0, portIrqFlag}, 8'h01);
        sb(8'h69, 8);
        check("receiveOverflowFlag", {7'h0, receiveOverflowFlag}, 8'h01);
        check("bufRdData", bufRdData, 8'h96);
        rd();
        cfg(4'h4, 1'h1);
        selectN <= 1'h0;
        sb(8'hc3, 4);
        selectN <= 1'h1;
        repeat (8) @(negedge clk_sys);
        check("serialOutOe", {7'h0, serialOutOe}, 8'h00);
        @(posedge clk_sys);
        selectN <= 1'h0;
        sb(8'h5a, 8);
        check("bufRdData", bufRdData, 8'h5a);
        check("serialOutOe", {7'h0, serialOutOe}, 8'h01);
        check("rxStreamData", rxStreamData, 8'h3c);
        rxStreamReady <= 1'h1;
        repeat (30) @(negedge clk_sys);
        check("rxStreamValid", {7'h0, rxStreamValid}, 8'h00);
        close_out();
    end
endmodule // sps_port_tb
bind sps_port sps_port_chk u_sps_port_chk (.clk_sys, .srst, .portEnable,
    .clockIdleLevel, .portModeField, .sleepMode, .bufWrite, .bufRead,
    .bufRdData, .bufferFullFlag, .portIrqFlag, .writeCollisionFlag,
    .receiveOverflowFlag, .sckOut, .sckOe, .serialOutOe, .selectN);
`default_nettype wire
